//--- hw/lfbp_top.sv
// Legacy link byte port top: two lanes, host register port, status,
// mask and interrupt.
// Assumes an 8-bit host port on CLK; framer strobes arrive as pins.
// Contract
// - Receive bits shift in, LSB first
// - Eight bits set receive full flag
// - Masked full event pulls interrupt low
// - Byte equal to match sets flag
// - Destuff drops zero after five ones
// - Zero after six ones is kept
// - Transmit byte sent LSB first
// - Eight bits sent set empty flag
// - Old byte resent if not rewritten
// - Stuffer inserts zero after five ones
// - Fs taken from byte with select clear
// - Multiframe load waits for boundary
// - Only one transmit source at once
// - Fs message fields use same registers
// - Each framer has own register set
`timescale 1ns/1ns
module lfbp_top
  import lfbp_pkg::*;
#(
  parameter int NLANES = 2
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Host register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Loose status, mask and control bits
  input wire logic [LFBP_NFLAGS-1:0] FLAG_CLR_A,
  input wire logic [LFBP_NFLAGS-1:0] FLAG_CLR_B,
  input wire logic [LFBP_NFLAGS-1:0] IRQ_MASK_A,
  input wire logic [LFBP_NFLAGS-1:0] IRQ_MASK_B,
  input wire logic [NLANES-1:0] ESF_MODE,
  input wire logic [NLANES-1:0] RX_ZERO_DESTUFF_EN,
  input wire logic [NLANES-1:0] TX_ZERO_STUFF_EN,
  input wire logic [NLANES-1:0] MULTIFRAME_LOAD_EN,
  input wire logic [NLANES-1:0] FS_SOURCE_SELECT,
  input wire logic [NLANES-1:0] HDLC_TX_ACTIVE,
  output logic [LFBP_NFLAGS-1:0] FLAGS_A,
  output logic [LFBP_NFLAGS-1:0] FLAGS_B,
  // Framer bit stream
  input wire logic [NLANES-1:0] RX_BIT_STB,
  input wire logic [NLANES-1:0] RX_BIT,
  input wire logic [NLANES-1:0] TX_BIT_STB,
  input wire logic [NLANES-1:0] TX_MF_STB,
  output logic [NLANES-1:0] TX_BIT,
  // Interrupt
  output logic INT_N
);

  typedef struct packed {
    logic [NLANES-1:0][2:0] rx_stb_sy;
    logic [NLANES-1:0][2:0] rx_bit_sy;
    logic [NLANES-1:0][2:0] tx_stb_sy;
    logic [NLANES-1:0][2:0] mf_stb_sy;
    logic [NLANES-1:0] rx_stb_lvl;
    logic [NLANES-1:0] tx_stb_lvl;
    logic [NLANES-1:0] mf_stb_lvl;
    logic [NLANES-1:0] rx_bit_lvl;
    logic [NLANES-1:0][7:0] match_one;
    logic [NLANES-1:0][7:0] match_two;
    logic [NLANES-1:0][7:0] tx_byte;
    logic [NLANES-1:0][LFBP_NFLAGS-1:0] flags;
    logic [7:0] rdata;
    logic irq_n;
  } lfbp_top_t;

  lfbp_top_t s_reg;
  lfbp_top_t s_next;
  logic [NLANES-1:0] rx_stb_p;
  logic [NLANES-1:0] tx_stb_p;
  logic [NLANES-1:0] mf_stb_p;
  logic [NLANES-1:0] tx_wr_p;
  logic [NLANES-1:0][7:0] rx_byte_w;
  logic [NLANES-1:0][LFBP_NFLAGS-1:0] ev_w;
  logic [NLANES-1:0][LFBP_NFLAGS-1:0] clr_w;
  logic [NLANES-1:0][LFBP_NFLAGS-1:0] mask_w;
  logic [NLANES-1:0] tx_bit_w;

  assign clr_w[0] = FLAG_CLR_A;
  assign clr_w[1] = FLAG_CLR_B;
  assign mask_w[0] = IRQ_MASK_A;
  assign mask_w[1] = IRQ_MASK_B;

  // ----------------------------------------------------------------------
  // Lanes, one register set each
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NLANES; g++)
    begin : gl
      lfbp_lane_if lif ();
      assign lif.rx_bit_stb = rx_stb_p[g];
      assign lif.rx_bit = s_reg.rx_bit_lvl[g];
      assign lif.tx_bit_stb = tx_stb_p[g];
      assign lif.tx_mf_stb = mf_stb_p[g];
      assign lif.esf_mode = ESF_MODE[g];
      assign lif.destuff_en = RX_ZERO_DESTUFF_EN[g];
      assign lif.stuff_en = TX_ZERO_STUFF_EN[g];
      assign lif.mf_load_en = MULTIFRAME_LOAD_EN[g];
      assign lif.fs_src_sel = FS_SOURCE_SELECT[g];
      // HDLC owns the transmit link while active
      assign lif.tx_src_en = !HDLC_TX_ACTIVE[g];
      assign lif.match_one = s_reg.match_one[g];
      assign lif.match_two = s_reg.match_two[g];
      assign lif.tx_byte = s_reg.tx_byte[g];
      assign lif.tx_byte_wr = tx_wr_p[g];
      assign rx_byte_w[g] = lif.rx_byte;
      assign ev_w[g][LFBP_FLAG_RXFULL] = lif.ev_rx_full;
      assign ev_w[g][LFBP_FLAG_MATCH] = lif.ev_match;
      assign ev_w[g][LFBP_FLAG_TXEMPTY] = lif.ev_tx_empty;
      assign tx_bit_w[g] = lif.tx_bit;
      lfbp_lane u_lane
      (
        .clk(CLK),
        .nrst(NRST),
        .lane(lif.lane)
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Pin qualification: second and third stage must agree
  // ----------------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    rx_stb_p = '0;
    tx_stb_p = '0;
    mf_stb_p = '0;
    tx_wr_p = '0;
    for (int i = 0; i < NLANES; i++)
    begin
      s_next.rx_stb_sy[i] = {s_reg.rx_stb_sy[i][1:0], RX_BIT_STB[i]};
      s_next.rx_bit_sy[i] = {s_reg.rx_bit_sy[i][1:0], RX_BIT[i]};
      s_next.tx_stb_sy[i] = {s_reg.tx_stb_sy[i][1:0], TX_BIT_STB[i]};
      s_next.mf_stb_sy[i] = {s_reg.mf_stb_sy[i][1:0], TX_MF_STB[i]};
      if (s_reg.rx_stb_sy[i][1] == s_reg.rx_stb_sy[i][2])
      begin
        s_next.rx_stb_lvl[i] = s_reg.rx_stb_sy[i][2];
      end
      if (s_reg.tx_stb_sy[i][1] == s_reg.tx_stb_sy[i][2])
      begin
        s_next.tx_stb_lvl[i] = s_reg.tx_stb_sy[i][2];
      end
      if (s_reg.mf_stb_sy[i][1] == s_reg.mf_stb_sy[i][2])
      begin
        s_next.mf_stb_lvl[i] = s_reg.mf_stb_sy[i][2];
      end
      if (s_reg.rx_bit_sy[i][1] == s_reg.rx_bit_sy[i][2])
      begin
        s_next.rx_bit_lvl[i] = s_reg.rx_bit_sy[i][2];
      end
      // Rising edge of qualified strobe is one event
      rx_stb_p[i] = s_next.rx_stb_lvl[i] && !s_reg.rx_stb_lvl[i];
      tx_stb_p[i] = s_next.tx_stb_lvl[i] && !s_reg.tx_stb_lvl[i];
      mf_stb_p[i] = s_next.mf_stb_lvl[i] && !s_reg.mf_stb_lvl[i];
      // Set wins over clear
      s_next.flags[i] = (s_reg.flags[i] & ~clr_w[i]) | ev_w[i];
    end
    // --------------------------------------------------------------------
    // Register writes and reads
    // --------------------------------------------------------------------
    if (WR)
    begin
      case (ADDR)
        LFBP_RX_MATCH_BYTE_ONE_A: s_next.match_one[0] = WDATA;
        LFBP_RX_MATCH_BYTE_TWO_A: s_next.match_two[0] = WDATA;
        LFBP_TX_LINK_BYTE_A:
        begin
          s_next.tx_byte[0] = WDATA;
          tx_wr_p[0] = 1'b1;
        end
        LFBP_RX_MATCH_BYTE_ONE_B: s_next.match_one[1] = WDATA;
        LFBP_RX_MATCH_BYTE_TWO_B: s_next.match_two[1] = WDATA;
        LFBP_TX_LINK_BYTE_B:
        begin
          s_next.tx_byte[1] = WDATA;
          tx_wr_p[1] = 1'b1;
        end
        default:
        begin
        end
      endcase
    end
    if (RD)
    begin
      case (ADDR)
        LFBP_RX_LINK_BYTE_A: s_next.rdata = rx_byte_w[0];
        LFBP_RX_MATCH_BYTE_ONE_A: s_next.rdata = s_reg.match_one[0];
        LFBP_RX_MATCH_BYTE_TWO_A: s_next.rdata = s_reg.match_two[0];
        LFBP_TX_LINK_BYTE_A: s_next.rdata = s_reg.tx_byte[0];
        LFBP_RX_LINK_BYTE_B: s_next.rdata = rx_byte_w[1];
        LFBP_RX_MATCH_BYTE_ONE_B: s_next.rdata = s_reg.match_one[1];
        LFBP_RX_MATCH_BYTE_TWO_B: s_next.rdata = s_reg.match_two[1];
        LFBP_TX_LINK_BYTE_B: s_next.rdata = s_reg.tx_byte[1];
        default: s_next.rdata = 8'h00;
      endcase
    end
    // --------------------------------------------------------------------
    // Interrupt: low while any masked flag stands
    // --------------------------------------------------------------------
    s_next.irq_n = 1'b1;
    for (int i = 0; i < NLANES; i++)
    begin
      if (|(s_next.flags[i] & mask_w[i]))
      begin
        s_next.irq_n = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      s_reg <= '0;
      s_reg.irq_n <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign RDATA = s_reg.rdata;
  assign FLAGS_A = s_reg.flags[0];
  assign FLAGS_B = s_reg.flags[1];
  assign TX_BIT = tx_bit_w;
  assign INT_N = s_reg.irq_n;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  full_irq_a: assert property (@(posedge CLK) disable iff (!NRST)
    (ev_w[0][LFBP_FLAG_RXFULL] && IRQ_MASK_A[LFBP_FLAG_RXFULL])
    |=> !INT_N)
    else $error("full event did not raise interrupt");
  match_irq_a: assert property (@(posedge CLK) disable iff (!NRST)
    (ev_w[1][LFBP_FLAG_MATCH] && IRQ_MASK_B[LFBP_FLAG_MATCH])
    |=> !INT_N)
    else $error("match event did not raise interrupt");
  empty_flag_a: assert property (@(posedge CLK) disable iff (!NRST)
    ev_w[0][LFBP_FLAG_TXEMPTY] |=> FLAGS_A[LFBP_FLAG_TXEMPTY])
    else $error("empty flag not set");
  flag_hold_a: assert property (@(posedge CLK) disable iff (!NRST)
    (FLAGS_A[LFBP_FLAG_RXFULL] && !FLAG_CLR_A[LFBP_FLAG_RXFULL])
    |=> FLAGS_A[LFBP_FLAG_RXFULL])
    else $error("flag dropped without clear");
  irq_idle_a: assert property (@(posedge CLK) disable iff (!NRST)
    (s_reg.flags[0] & IRQ_MASK_A) == '0
      && (s_reg.flags[1] & IRQ_MASK_B) == '0
      && $stable(IRQ_MASK_A) && $stable(IRQ_MASK_B)
      && $stable(s_reg.flags) |-> INT_N)
    else $error("interrupt low without cause");
  full_flag_a: assert property (@(posedge CLK) disable iff (!NRST)
    ev_w[1][LFBP_FLAG_RXFULL] |=> FLAGS_B[LFBP_FLAG_RXFULL])
    else $error("full flag not set");

endmodule : lfbp_top

//--- inc/lfbp_pkg.sv
// Package for the legacy link byte port: register map, field positions,
// reset values and timing constants.
// Assumes an 8-bit parallel host port with byte addresses.
package lfbp_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] LFBP_RX_LINK_BYTE_A = 8'h28;
  localparam logic [7:0] LFBP_RX_MATCH_BYTE_ONE_A = 8'h29;
  localparam logic [7:0] LFBP_RX_MATCH_BYTE_TWO_A = 8'h2a;
  localparam logic [7:0] LFBP_TX_LINK_BYTE_A = 8'h7e;
  localparam logic [7:0] LFBP_RX_LINK_BYTE_B = 8'hc8;
  localparam logic [7:0] LFBP_RX_MATCH_BYTE_ONE_B = 8'hc9;
  localparam logic [7:0] LFBP_RX_MATCH_BYTE_TWO_B = 8'hca;
  localparam logic [7:0] LFBP_TX_LINK_BYTE_B = 8'hfe;

  // ----------------------------------------------------------------------
  // Field positions of the loose status, mask and control bits
  // ----------------------------------------------------------------------
  localparam int LFBP_FLAG_MATCH = 0;
  localparam int LFBP_FLAG_TXEMPTY = 1;
  localparam int LFBP_FLAG_RXFULL = 2;
  localparam int LFBP_NFLAGS = 3;

  // ----------------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------------
  localparam logic [7:0] LFBP_BYTE_RESET = 8'h00;
  localparam logic [7:0] LFBP_FS_PATTERN = 8'h1c;
  localparam int LFBP_BYTE_BITS = 8;
  localparam int LFBP_STUFF_RUN = 5;
  localparam logic [2:0] LFBP_RUN_MAX = 3'h7;

  // Bit period 250 us, byte period 2 ms, at a 10 ns clock
  localparam int LFBP_CLK_NS = 10;
  localparam int LFBP_BIT_US = 250;
  localparam int LFBP_BYTE_US = 2000;
  localparam int LFBP_BYTE_CYCLES = LFBP_BYTE_US * 1000 / LFBP_CLK_NS;

  typedef enum logic [1:0] {LFBP_FMT_ESF, LFBP_FMT_D4} lfbp_fmt_t;

endpackage : lfbp_pkg

//--- inc/lfbp_lane_if.sv
// Interface carrying one framer lane between the top and a lane module.
// Assumes both ends on CLK; strobes are one-cycle pulses.
`timescale 1ns/1ns
interface lfbp_lane_if;
  logic rx_bit_stb;
  logic rx_bit;
  logic tx_bit_stb;
  logic tx_mf_stb;
  logic tx_bit;
  logic esf_mode;
  logic destuff_en;
  logic stuff_en;
  logic mf_load_en;
  logic fs_src_sel;
  logic tx_src_en;
  logic [7:0] match_one;
  logic [7:0] match_two;
  logic [7:0] tx_byte;
  logic tx_byte_wr;
  logic [7:0] rx_byte;
  logic ev_rx_full;
  logic ev_match;
  logic ev_tx_empty;

  modport lane
  (
    input rx_bit_stb, rx_bit, tx_bit_stb, tx_mf_stb, esf_mode,
    input destuff_en, stuff_en, mf_load_en, fs_src_sel, tx_src_en,
    input match_one, match_two, tx_byte, tx_byte_wr,
    output tx_bit, rx_byte, ev_rx_full, ev_match, ev_tx_empty
  );
  modport top
  (
    output rx_bit_stb, rx_bit, tx_bit_stb, tx_mf_stb, esf_mode,
    output destuff_en, stuff_en, mf_load_en, fs_src_sel, tx_src_en,
    output match_one, match_two, tx_byte, tx_byte_wr,
    input tx_bit, rx_byte, ev_rx_full, ev_match, ev_tx_empty
  );
endinterface : lfbp_lane_if

//--- hw/lfbp_lane.sv
// One framer lane: receive shifter with destuffer and match, transmit
// shifter with zero stuffer.
// Assumes bit strobes already synchronised to CLK, one cycle each.
`timescale 1ns/1ns
module lfbp_lane
  import lfbp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Lane signals
  lfbp_lane_if.lane lane
);

  typedef struct packed {
    logic [7:0] rx_sh;
    logic [3:0] rx_cnt;
    logic [2:0] rx_ones;
    logic [7:0] rx_byte;
    logic rx_full;
    logic match;
    logic [7:0] tx_sh;
    logic [3:0] tx_cnt;
    logic [2:0] tx_ones;
    logic tx_bit;
    logic tx_empty;
    logic tx_pend;
  } lfbp_lane_t;

  lfbp_lane_t s_reg;
  lfbp_lane_t s_next;
  logic drop_zero;
  logic stuff_now;
  logic load_ok;
  logic tx_go;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.rx_full = 1'b0;
    s_next.match = 1'b0;
    s_next.tx_empty = 1'b0;
    // Run of exactly five ones then a zero is a stuffed zero
    drop_zero = lane.destuff_en && !lane.rx_bit
      && s_reg.rx_ones == 3'(LFBP_STUFF_RUN);
    stuff_now = lane.stuff_en && s_reg.tx_ones == 3'(LFBP_STUFF_RUN);
    // In D4 with multiframe load, reload waits for a boundary
    load_ok = !lane.mf_load_en || lane.esf_mode || lane.tx_mf_stb;
    // Fs select set in D4 hands the Fs slot to another source
    tx_go = lane.tx_bit_stb && lane.tx_src_en
      && (lane.esf_mode || !lane.fs_src_sel);
    if (lane.tx_byte_wr)
    begin
      s_next.tx_pend = 1'b1;
    end
    if (lane.rx_bit_stb)
    begin
      if (lane.rx_bit)
      begin
        if (s_reg.rx_ones != LFBP_RUN_MAX)
        begin
          s_next.rx_ones = s_reg.rx_ones + 3'h1;
        end
      end
      else
      begin
        s_next.rx_ones = 3'h0;
      end
      if (!drop_zero)
      begin
        // LSB first: shift in at the top
        s_next.rx_sh = {lane.rx_bit, s_reg.rx_sh[7:1]};
        if (s_reg.rx_cnt == 4'(LFBP_BYTE_BITS - 1))
        begin
          s_next.rx_cnt = 4'h0;
          // Unread byte is overwritten, as the host is given 2 ms
          s_next.rx_byte = {lane.rx_bit, s_reg.rx_sh[7:1]};
          s_next.rx_full = 1'b1;
          s_next.match = ({lane.rx_bit, s_reg.rx_sh[7:1]} == lane.match_one)
            || ({lane.rx_bit, s_reg.rx_sh[7:1]} == lane.match_two);
        end
        else
        begin
          s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
        end
      end
    end
    if (tx_go)
    begin
      if (stuff_now)
      begin
        s_next.tx_bit = 1'b0;
        s_next.tx_ones = 3'h0;
      end
      else if (s_reg.tx_cnt == 4'(LFBP_BYTE_BITS) && !load_ok)
      begin
        // Hold line idle at previous bit until boundary
        s_next.tx_bit = s_reg.tx_bit;
      end
      else
      begin
        if (s_reg.tx_cnt == 4'(LFBP_BYTE_BITS))
        begin
          // Old byte is sent again if host wrote nothing new
          s_next.tx_sh = lane.tx_byte;
          s_next.tx_cnt = 4'h1;
          s_next.tx_bit = lane.tx_byte[0];
          s_next.tx_sh = {1'b0, lane.tx_byte[7:1]};
          s_next.tx_pend = lane.tx_byte_wr;
        end
        else
        begin
          s_next.tx_bit = s_reg.tx_sh[0];
          s_next.tx_sh = {1'b0, s_reg.tx_sh[7:1]};
          s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
          if (s_reg.tx_cnt == 4'(LFBP_BYTE_BITS - 1))
          begin
            s_next.tx_empty = 1'b1;
          end
        end
        s_next.tx_ones = s_next.tx_bit
          ? ((s_reg.tx_ones == LFBP_RUN_MAX) ? s_reg.tx_ones
            : s_reg.tx_ones + 3'h1)
          : 3'h0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_reg <= '0;
      s_reg.tx_cnt <= 4'(LFBP_BYTE_BITS);
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign lane.tx_bit = s_reg.tx_bit;
  assign lane.rx_byte = s_reg.rx_byte;
  assign lane.ev_rx_full = s_reg.rx_full;
  assign lane.ev_match = s_reg.match;
  assign lane.ev_tx_empty = s_reg.tx_empty;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  match_on_full_a: assert property (@(posedge clk) disable iff (!nrst)
    s_reg.match |-> s_reg.rx_full)
    else $error("match event without full byte");
  stuff_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    (tx_go && stuff_now) |=> !s_reg.tx_bit)
    else $error("stuffed bit not zero");
  keep_six_a: assert property (@(posedge clk) disable iff (!nrst)
    (lane.rx_bit_stb && !lane.rx_bit && s_reg.rx_ones > 3'(LFBP_STUFF_RUN))
    |=> s_reg.rx_sh[7] == 1'b0)
    else $error("zero after long run dropped");
  drop_five_a: assert property (@(posedge clk) disable iff (!nrst)
    (lane.rx_bit_stb && lane.destuff_en && !lane.rx_bit
      && s_reg.rx_ones == 3'(LFBP_STUFF_RUN))
    |=> $stable(s_reg.rx_cnt))
    else $error("stuffed zero counted");

endmodule : lfbp_lane

//--- test/lfbp_framer_model.sv
// Framer bit stream model for both lanes of the link byte port.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ns
module lfbp_framer_model
(
  // Clock
  input wire logic clk,
  // Bit stream
  output logic [1:0] rx_bit_stb,
  output logic [1:0] rx_bit,
  output logic [1:0] tx_bit_stb,
  output logic [1:0] tx_mf_stb,
  input wire logic [1:0] tx_bit
);
  initial
  begin
    rx_bit_stb = 2'h0;
    rx_bit = 2'h0;
    tx_bit_stb = 2'h0;
    tx_mf_stb = 2'h0;
  end

  // One received bit, settled well before and after its strobe
  task automatic rx_send(input int l, input logic b);
    @(posedge clk) rx_bit[l] <= b;
    repeat (5) @(posedge clk);
    rx_bit_stb[l] <= 1'b1;
    repeat (4) @(posedge clk);
    rx_bit_stb[l] <= 1'b0;
    repeat (4) @(posedge clk);
    // Hold is over: show the opposite level so stale data cannot pass
    rx_bit[l] <= ~b;
  endtask

  // One transmit slot; mf marks a multiframe boundary
  task automatic tx_step(input int l, input logic mf, output logic b);
    @(posedge clk) tx_bit_stb[l] <= 1'b1;
    tx_mf_stb[l] <= mf;
    repeat (4) @(posedge clk);
    tx_bit_stb[l] <= 1'b0;
    tx_mf_stb[l] <= 1'b0;
    repeat (5) @(posedge clk);
    #1 b = tx_bit[l];
  endtask
endmodule // lfbp_framer_model

//--- test/testbench.sv
// Self-checking bench for the legacy link byte port top.
// Assumes the framer model is compiled before this file.
`timescale 1ns/1ns
module testbench;
  import lfbp_pkg::*;
  logic clk, nrst, wr, rd, int_n;
  logic [7:0] addr, wdata, rdata, v;
  logic [2:0] clr_a, clr_b, mask_a, mask_b, flags_a, flags_b, ef;
  logic [1:0] esf, dstf, stf, mfl, fss, hdlc, rxs, rxb, txs, txm, txb;
  logic [7:0] regs [8];
  logic [7:0] w [8];
  int n_errors, comparisons;

  lfbp_top dut
  (
    .CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .FLAG_CLR_A(clr_a), .FLAG_CLR_B(clr_b),
    .IRQ_MASK_A(mask_a), .IRQ_MASK_B(mask_b), .ESF_MODE(esf),
    .RX_ZERO_DESTUFF_EN(dstf), .TX_ZERO_STUFF_EN(stf),
    .MULTIFRAME_LOAD_EN(mfl), .FS_SOURCE_SELECT(fss),
    .HDLC_TX_ACTIVE(hdlc), .FLAGS_A(flags_a), .FLAGS_B(flags_b),
    .RX_BIT_STB(rxs), .RX_BIT(rxb), .TX_BIT_STB(txs),
    .TX_MF_STB(txm), .TX_BIT(txb), .INT_N(int_n)
  );
  lfbp_framer_model fw
  (
    .clk(clk), .rx_bit_stb(rxs), .rx_bit(rxb), .tx_bit_stb(txs),
    .tx_mf_stb(txm), .tx_bit(txb)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------
  // Checks and host port tasks
  // ------
  task automatic chk_byte(input logic [7:0] g, e, input string m);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, e, input string m);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch at %0t: %s got %b want %b", $time, m, g, e);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic done(input string t);
    $display("test %s done", t);
  endtask
  task automatic wr_reg(input logic [7:0] a, dv);
    @(posedge clk) addr <= a;
    wdata <= dv;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk) addr <= a;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    #1 q = rdata;
  endtask
  task automatic clear_flags;
    @(posedge clk) clr_a <= 3'h7;
    clr_b <= 3'h7;
    @(posedge clk) clr_a <= 3'h0;
    clr_b <= 3'h0;
    repeat (2) @(posedge clk);
    #1 chk_bit(int_n, 1'b1, "irq after clear");
  endtask
  function automatic logic [2:0] fl(input int l);
    return l ? flags_b : flags_a;
  endfunction
  // Receive byte after optional zero removal, first bit ends in bit 0
  function automatic logic [7:0] exp_rx(input logic [15:0] s, int n,
                                        input logic ds);
    logic [7:0] r;
    int run;
    r = 8'h00;
    run = 0;
    for (int i = 0; i < n; i++)
    begin
      if (!(ds && !s[i] && run == 5))
        r = {s[i], r[7:1]};
      run = s[i] ? run + 1 : 0;
    end
    return r;
  endfunction

  // ------
  // Lane scenarios
  // ------
  task automatic rx_case(input int l, input logic [15:0] s, input int n);
    logic [7:0] q, e;
    clear_flags();
    for (int i = 0; i < n; i++)
      fw.rx_send(l, s[i]);
    repeat (4) @(posedge clk);
    e = exp_rx(s, n, dstf[l]);
    ef = {1'b1, 1'b0, e === w[l*4+1] || e === w[l*4+2]};
    rd_reg(regs[l*4], q);
    chk_byte(q, e, "rx byte");
    chk_byte({5'h0, fl(l)}, {5'h0, ef}, "rx flags");
    chk_bit(int_n, ~|(ef & (l ? mask_b : mask_a)), "irq");
  endtask
  task automatic tx_run(input int l, input logic mf, input logic [15:0] e,
                        input int n, input logic empt);
    logic q;
    logic [2:0] f;
    for (int i = 0; i < n; i++)
    begin
      fw.tx_step(l, mf && i == 0, q);
      f = fl(l);
      chk_bit(q, e[i], "tx bit");
      chk_bit(f[LFBP_FLAG_TXEMPTY], empt && i == n - 1, "empty");
    end
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    results();
  end

  initial
  begin
    {nrst, wr, rd, addr, wdata, clr_a, clr_b} = '0;
    {dstf, stf, mfl, fss, hdlc} = '0;
    mask_a = 3'h0;
    mask_b = 3'h0;
    esf = 2'h3;
    n_errors = 0;
    comparisons = 0;
    regs = '{LFBP_RX_LINK_BYTE_A, LFBP_RX_MATCH_BYTE_ONE_A,
             LFBP_RX_MATCH_BYTE_TWO_A, LFBP_TX_LINK_BYTE_A,
             LFBP_RX_LINK_BYTE_B, LFBP_RX_MATCH_BYTE_ONE_B,
             LFBP_RX_MATCH_BYTE_TWO_B, LFBP_TX_LINK_BYTE_B};
    v = 8'($urandom(86));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1 chk_byte({txb, flags_a, flags_b}, 8'h00, "reset outputs");
    chk_bit(int_n, 1'b1, "reset irq");
    // Map: reset values, read-only places, per-framer independence
    for (int i = 0; i < 8; i++)
    begin
      rd_reg(regs[i], v);
      chk_byte(v, LFBP_BYTE_RESET, "reset value");
      w[i] = 8'($urandom);
      wr_reg(regs[i], w[i]);
    end
    w[0] = 8'h00;
    w[4] = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      rd_reg(regs[i], v);
      chk_byte(v, w[i], "readback");
    end
    rd_reg(8'h00, v);
    chk_byte(v, 8'h00, "unmapped");
    done("registers");
    // Zero removal, then a flag pattern that must pass intact
    @(posedge clk) dstf <= 2'h1;
    mask_a <= 3'h4;
    rx_case(0, 16'h01be, 9);
    rx_case(0, 16'h007e, 8);
    @(posedge clk) dstf <= 2'h0;
    done("destuff");
    for (int l = 0; l < 2; l++)
      for (int i = 0; i < 3; i++)
      begin
        v = 8'($urandom);
        if (i > 0)
        begin
          wr_reg(regs[l*4+i], v);
          w[l*4+i] = v;
        end
        @(posedge clk) mask_a <= 3'($urandom);
        mask_b <= 3'($urandom);
        rx_case(l, {8'h00, v}, 8);
        done("rx byte");
      end
    // Transmit, then resend when not rewritten
    v = 8'($urandom);
    wr_reg(LFBP_TX_LINK_BYTE_A, v);
    clear_flags();
    @(posedge clk) mask_a <= 3'h2;
    mask_b <= 3'h0;
    tx_run(0, 1'b0, {8'h00, v}, 8, 1'b1);
    #1 chk_bit(int_n, 1'b0, "tx irq");
    clear_flags();
    tx_run(0, 1'b0, {8'h00, v}, 8, 1'b1);
    done("tx esf");
    // D4 framing pattern loaded on multiframe boundaries only
    @(posedge clk) esf[0] <= 1'b0;
    mfl[0] <= 1'b1;
    fss[0] <= 1'b0;
    wr_reg(LFBP_TX_LINK_BYTE_A, LFBP_FS_PATTERN);
    clear_flags();
    tx_run(0, 1'b0, {16{v[7]}}, 2, 1'b0);
    tx_run(0, 1'b1, {8'h00, LFBP_FS_PATTERN}, 8, 1'b1);
    wr_reg(LFBP_TX_LINK_BYTE_A, 8'he3);
    clear_flags();
    @(posedge clk) fss[0] <= 1'b1;
    tx_run(0, 1'b1, 16'h0000, 1, 1'b0);
    @(posedge clk) fss[0] <= 1'b0;
    tx_run(0, 1'b1, 16'h0001, 1, 1'b0);
    done("tx d4");
    // Stuffing on lane B, then the other transmit source takes over
    @(posedge clk) stf <= 2'h2;
    wr_reg(LFBP_TX_LINK_BYTE_B, 8'hff);
    clear_flags();
    tx_run(1, 1'b0, 16'h01df, 9, 1'b1);
    wr_reg(LFBP_TX_LINK_BYTE_B, 8'h00);
    clear_flags();
    @(posedge clk) hdlc <= 2'h2;
    tx_run(1, 1'b0, 16'h0001, 1, 1'b0);
    @(posedge clk) hdlc <= 2'h0;
    tx_run(1, 1'b0, 16'h0000, 1, 1'b0);
    done("tx stuff");
    results();
  end
endmodule // testbench
